// [lfdpa_link_regs.sv]
/*
 * Queue partition, diagnostic and transceiver access register group.
 * Assumes AXI4-Lite at 50 MHz, and queue and transceiver logic on the same clock.
 */
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/10ps
module lfdpa_link_regs
    import lfdpa_pkg::*;
(
    // clock and reset
    input logic aclk,
    input logic aresetn,
    // AXI4-Lite write
    input logic awvalid,
    output logic awready,
    input logic [7:0] awaddr,
    input logic wvalid,
    output logic wready,
    input logic [31:0] wdata,
    input logic [3:0] wstrb,
    output logic bvalid,
    input logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read
    input logic arvalid,
    output logic arready,
    input logic [7:0] araddr,
    output logic rvalid,
    input logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // queue control
    output logic flush_async_tx_queue,
    output logic flush_iso_tx_queue,
    output logic flush_general_rx_queue,
    output logic [DEPTH_W-1:0] async_tx_queue_depth,
    output logic [DEPTH_W-1:0] iso_tx_queue_depth,
    output logic [9:0] general_rx_queue_depth,
    output logic [QWORD_W-1:0] queue_word_mask,
    // partial read trigger
    input logic partial_read_enable,
    input logic bad_header_flag,
    output logic trigger_size_active,
    output logic [DEPTH_W-1:0] trigger_size_quadlets,
    // diagnostics
    output logic capture_all_enable,
    output logic full_write_unlock,
    // transceiver access
    output logic phy_req_valid,
    input logic phy_req_ready,
    output lfdpa_phy_req_t phy_req,
    input logic phy_reply_valid,
    input lfdpa_phy_reply_t phy_reply,
    output logic transceiver_info_irq
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [DEPTH_W-1:0] trig;
        logic [DEPTH_W-1:0] atx;
        logic [DEPTH_W-1:0] itx;
        logic [2:0] flush;
        logic capture;
        logic unlock;
        logic rd_req;
        logic wr_req;
        logic [3:0] req_addr;
        logic [7:0] req_wdata;
        logic [3:0] rep_addr;
        logic [7:0] rep_data;
        logic irq;
        logic trig_on;
        logic [9:0] grx;
    } lfdpa_regs_t;

    lfdpa_regs_t q_r;
    lfdpa_regs_t q_nxt;

    logic wr_en;
    lfdpa_wcmd_t wr_cmd;
    logic [7:0] rd_addr;
    logic [31:0] rd_data;
    logic [2:0] wr_sel;
    logic [2:0] rd_sel;
    logic [31:0] wv;
    logic set_rd;
    logic set_wr;
    logic done_rd;
    logic done_wr;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // one-hot select: bit0 queue ctrl, bit1 diagnostic, bit2 transceiver port
    function automatic logic [2:0] reg_decode(input logic [7:0] a);
        reg_decode = {a == OFS_TRANSCEIVER_REG_PORT, a == OFS_TEST_OBSERVE_CTRL,
                      a == OFS_QUEUE_PARTITION_CTRL};
    endfunction

    function automatic logic [31:0] wmerge(input logic [31:0] cur, input lfdpa_wcmd_t c);
        logic [31:0] m;
        m = '0;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{c.strb[i]}};
        end
        wmerge = (cur & ~m) | (c.data & m);
    endfunction

    // flush bits always read zero
    function automatic logic [31:0] view_qc(input lfdpa_regs_t s);
        view_qc = RST_QUEUE_PARTITION_CTRL;
        view_qc[QC_TRIG_LSB +: DEPTH_W] = s.trig;
        view_qc[QC_ATX_LSB +: DEPTH_W] = s.atx;
        view_qc[QC_ITX_LSB +: DEPTH_W] = s.itx;
    endfunction

    function automatic logic [31:0] view_dg(input lfdpa_regs_t s);
        view_dg = RST_TEST_OBSERVE_CTRL;
        view_dg[DG_CAPTURE_BIT] = s.capture;
        view_dg[DG_UNLOCK_BIT] = s.unlock;
    endfunction

    function automatic logic [31:0] view_tp(input lfdpa_regs_t s);
        view_tp = RST_TRANSCEIVER_REG_PORT;
        view_tp[TP_RD_BIT] = s.rd_req;
        view_tp[TP_WR_BIT] = s.wr_req;
        view_tp[TP_ADDR_LSB +: 4] = s.req_addr;
        view_tp[TP_WDATA_LSB +: 8] = s.req_wdata;
        view_tp[TP_RADDR_LSB +: 4] = s.rep_addr;
        view_tp[TP_RDATA_LSB +: 8] = s.rep_data;
    endfunction

    // receive share; floors at zero if software oversubscribes
    function automatic logic [9:0] grx_depth(input logic [DEPTH_W-1:0] a, input logic [DEPTH_W-1:0] i);
        logic [9:0] sum;
        sum = {1'b0, a} + {1'b0, i};
        grx_depth = (sum > QUEUE_TOTAL_QUADS) ? 10'h000 : QUEUE_TOTAL_QUADS - sum;
    endfunction

    // ------------------------------------------------------------
    // bus front end and request sequencer
    // ------------------------------------------------------------
    lfdpa_axil_slave u_axil (
        .aclk(aclk),
        .aresetn(aresetn),
        .awvalid(awvalid),
        .awready(awready),
        .awaddr(awaddr),
        .wvalid(wvalid),
        .wready(wready),
        .wdata(wdata),
        .wstrb(wstrb),
        .bvalid(bvalid),
        .bready(bready),
        .bresp(bresp),
        .arvalid(arvalid),
        .arready(arready),
        .araddr(araddr),
        .rvalid(rvalid),
        .rready(rready),
        .rdata(rdata),
        .rresp(rresp),
        .wr_en(wr_en),
        .wr_cmd(wr_cmd),
        .wr_hit(|wr_sel),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_hit(|rd_sel)
    );

    lfdpa_phy_seq u_seq (
        .aclk(aclk),
        .aresetn(aresetn),
        .rd_pend(q_r.rd_req),
        .wr_pend(q_r.wr_req),
        .req_addr(q_r.req_addr),
        .req_wdata(q_r.req_wdata),
        .done_rd(done_rd),
        .done_wr(done_wr),
        .phy_req_valid(phy_req_valid),
        .phy_req_ready(phy_req_ready),
        .phy_req(phy_req)
    );

    // ------------------------------------------------------------
    // register read
    // ------------------------------------------------------------
    assign wr_sel = reg_decode(wr_cmd.addr);
    assign rd_sel = reg_decode(rd_addr);

    always_comb begin
        rd_data = 32'h0000_0000;
        unique case (1'b1)
            rd_sel[0]: rd_data = view_qc(q_r);
            rd_sel[1]: rd_data = view_dg(q_r);
            rd_sel[2]: rd_data = view_tp(q_r);
            default: rd_data = 32'h0000_0000;
        endcase
    end

    // ------------------------------------------------------------
    // register update
    // ------------------------------------------------------------
    always_comb begin
        q_nxt = q_r;
        wv = 32'h0000_0000;
        set_rd = 1'b0;
        set_wr = 1'b0;
        q_nxt.flush = 3'h0;
        q_nxt.irq = phy_reply_valid;
        q_nxt.trig_on = partial_read_enable & ~bad_header_flag;
        if (wr_en && wr_sel[0]) begin
            wv = wmerge(view_qc(q_r), wr_cmd);
            q_nxt.flush = {wv[QC_FLUSH_GRX_BIT], wv[QC_FLUSH_ITX_BIT], wv[QC_FLUSH_ATX_BIT]};
            q_nxt.trig = wv[QC_TRIG_LSB +: DEPTH_W];
            q_nxt.atx = wv[QC_ATX_LSB +: DEPTH_W];
            q_nxt.itx = wv[QC_ITX_LSB +: DEPTH_W];
        end
        if (wr_en && wr_sel[1]) begin
            wv = wmerge(view_dg(q_r), wr_cmd);
            q_nxt.capture = wv[DG_CAPTURE_BIT];
            q_nxt.unlock = wv[DG_UNLOCK_BIT];
        end
        if (wr_en && wr_sel[2]) begin
            wv = wmerge(view_tp(q_r), wr_cmd);
            set_rd = wv[TP_RD_BIT];
            set_wr = wv[TP_WR_BIT];
            q_nxt.req_addr = wv[TP_ADDR_LSB +: 4];
            q_nxt.req_wdata = wv[TP_WDATA_LSB +: 8];
            if (q_r.unlock) begin
                q_nxt.rep_addr = wv[TP_RADDR_LSB +: 4];
                q_nxt.rep_data = wv[TP_RDATA_LSB +: 8];
            end
        end
        // a new software request wins over the sequencer's clear
        q_nxt.rd_req = set_rd | (q_r.rd_req & ~done_rd);
        q_nxt.wr_req = set_wr | (q_r.wr_req & ~done_wr);
        if (phy_reply_valid) begin
            q_nxt.rep_addr = phy_reply.addr;
            q_nxt.rep_data = phy_reply.data;
        end
        q_nxt.grx = grx_depth(q_nxt.atx, q_nxt.itx);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            // both depths reset to zero, so the receive share is the whole memory
            q_r <= '{grx: QUEUE_TOTAL_QUADS, default: '0};
        end else begin
            q_r <= q_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign flush_async_tx_queue = q_r.flush[0];
    assign flush_iso_tx_queue = q_r.flush[1];
    assign flush_general_rx_queue = q_r.flush[2];
    assign async_tx_queue_depth = q_r.atx;
    assign iso_tx_queue_depth = q_r.itx;
    assign general_rx_queue_depth = q_r.grx;
    assign trigger_size_active = q_r.trig_on;
    assign trigger_size_quadlets = q_r.trig_on ? q_r.trig : '0;
    assign capture_all_enable = q_r.capture;
    assign full_write_unlock = q_r.unlock;
    assign transceiver_info_irq = q_r.irq;
    // top bit of each queue word marks a packet start or token
    assign queue_word_mask = {1'b1, {(QWORD_W-1){1'b0}}};

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_wr_qc(int b);
        wr_en && wr_sel[0] && wr_cmd.strb[b/8] && wr_cmd.data[b];
    endsequence

    sequence s_reply;
        phy_reply_valid ##1 transceiver_info_irq;
    endsequence

    AST_FLUSH_ATX: assert property (s_wr_qc(QC_FLUSH_ATX_BIT) |=> flush_async_tx_queue ##1 !flush_async_tx_queue)
        else $error("async flush pulse wrong");
    AST_FLUSH_ITX: assert property (s_wr_qc(QC_FLUSH_ITX_BIT) |=> flush_iso_tx_queue ##1 !flush_iso_tx_queue)
        else $error("iso flush pulse wrong");
    AST_FLUSH_GRX: assert property (s_wr_qc(QC_FLUSH_GRX_BIT) |=> flush_general_rx_queue)
        else $error("receive flush pulse missing");
    AST_FLUSH_QUIET: assert property (!(wr_en && wr_sel[0]) |=> q_r.flush == 3'h0)
        else $error("flush without write");
    AST_TRIG_GATE: assert property ((!partial_read_enable || bad_header_flag) |=> !trigger_size_active)
        else $error("trigger active while gated");
    AST_TRIG_VAL: assert property (trigger_size_active |-> trigger_size_quadlets == q_r.trig)
        else $error("trigger size mismatch");
    AST_GRX_SUM: assert property (({1'b0, async_tx_queue_depth} + {1'b0, iso_tx_queue_depth} <= 11'h200)
        |-> general_rx_queue_depth + async_tx_queue_depth + iso_tx_queue_depth == 11'h200)
        else $error("receive depth not the remainder");
    AST_DG_RSVD: assert property (rd_sel[1] |-> (rd_data & ~(32'h8000_0000 | 32'h0800_0000)) == 32'h0)
        else $error("diagnostic reserved bit set");
    AST_REPLY: assert property (s_reply |-> q_r.rep_addr == $past(phy_reply.addr)
        && q_r.rep_data == $past(phy_reply.data))
        else $error("reply not captured");
    AST_IRQ: assert property (phy_reply_valid |=> transceiver_info_irq)
        else $error("info flag not raised");
    AST_REPLY_HOLD: assert property ((!phy_reply_valid && !(wr_en && wr_sel[2] && q_r.unlock))
        |=> $stable(q_r.rep_data) && $stable(q_r.rep_addr))
        else $error("reply field changed");
    AST_RD_CLR: assert property ((done_rd && !(wr_en && wr_sel[2])) |=> !q_r.rd_req)
        else $error("read request bit not cleared");
    AST_WR_CLR: assert property ((done_wr && !(wr_en && wr_sel[2])) |=> !q_r.wr_req)
        else $error("write request bit not cleared");
    AST_REQ_OUT: assert property ((q_r.wr_req && !q_r.rd_req && !phy_req_valid && !done_wr && !done_rd)
        |=> phy_req_valid && phy_req.is_write)
        else $error("write request not issued");
    AST_RESET: assert property ($rose(aresetn) |-> q_r.capture == 1'b0 && q_r.unlock == 1'b0
        && q_r.rep_data == 8'h00 && q_r.rd_req == 1'b0)
        else $error("register not zero after reset");
endmodule

// [lfdpa_pkg.sv]
/*
 * Constants and carrier types shared by the link register group.
 * Assumes a single 50 MHz clock and a 32-bit AXI4-Lite register bus.
 * Documented bit 0 is the MSB: documented bit n sits at hardware bit 31-n.
 */
// Functional notes
// - write one flushes async transmit queue, self-clears
// - write one flushes iso transmit queue, self-clears
// - write one flushes general receive queue, self-clears
// - trigger size field, quadlets, for partial reads
// - trigger ignored unless enabled and header good
// - receive depth is 512 minus both depths
// - snoop and unlock always writable, others locked
// - snoop enable makes receiver capture every packet
// - unlock makes normally read-only bits writable
// - upper half requests, lower half phy replies
// - read request sent, then bit clears
// - write request sent, then bit clears
// - request address and write data fields
// - reply loads responding address and data
// - new phy reply raises info interrupt flag
// - diagnostic and phy registers reset zero
// - queue words are 33 bits with marker
package lfdpa_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_QUEUE_PARTITION_CTRL = 8'h1C;
    localparam logic [7:0] OFS_TEST_OBSERVE_CTRL = 8'h20;
    localparam logic [7:0] OFS_TRANSCEIVER_REG_PORT = 8'h24;
    localparam logic [31:0] RST_QUEUE_PARTITION_CTRL = 32'h0000_0000;
    localparam logic [31:0] RST_TEST_OBSERVE_CTRL = 32'h0000_0000;
    localparam logic [31:0] RST_TRANSCEIVER_REG_PORT = 32'h0000_0000;

    // ------------------------------------------------------------
    // field positions (hardware bit index, lsb = 0)
    // ------------------------------------------------------------
    localparam int QC_FLUSH_ATX_BIT = 31;
    localparam int QC_FLUSH_ITX_BIT = 30;
    localparam int QC_FLUSH_GRX_BIT = 29;
    localparam int QC_TRIG_LSB = 18;
    localparam int QC_ATX_LSB = 9;
    localparam int QC_ITX_LSB = 0;
    localparam int DG_CAPTURE_BIT = 31;
    localparam int DG_UNLOCK_BIT = 27;
    localparam int TP_RD_BIT = 31;
    localparam int TP_WR_BIT = 30;
    localparam int TP_ADDR_LSB = 24;
    localparam int TP_WDATA_LSB = 16;
    localparam int TP_RADDR_LSB = 8;
    localparam int TP_RDATA_LSB = 0;

    // ------------------------------------------------------------
    // sizes and bus answers
    // ------------------------------------------------------------
    localparam int DEPTH_W = 9;
    localparam logic [9:0] QUEUE_TOTAL_QUADS = 10'h200;
    localparam int QWORD_W = 33;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } lfdpa_wcmd_t;

    typedef struct packed {
        logic is_write;
        logic [3:0] addr;
        logic [7:0] wdata;
    } lfdpa_phy_req_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] data;
    } lfdpa_phy_reply_t;

    typedef struct packed {
        logic first_mark;
        logic [31:0] data;
    } lfdpa_qword_t;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'h0,
        SEQ_SEND = 2'h1,
        SEQ_DONE = 2'h3
    } lfdpa_seq_t;
endpackage

// [lfdpa_axil_slave.sv]
/*
 * AXI4-Lite slave front end: one write and one read at a time.
 * Assumes the parent decodes the address and answers hit/data combinationally.
 */
`timescale 1ns/10ps
module lfdpa_axil_slave
    import lfdpa_pkg::*;
(
    // clock and reset
    input logic aclk,
    input logic aresetn,
    // write channels
    input logic awvalid,
    output logic awready,
    input logic [7:0] awaddr,
    input logic wvalid,
    output logic wready,
    input logic [31:0] wdata,
    input logic [3:0] wstrb,
    output logic bvalid,
    input logic bready,
    output logic [1:0] bresp,
    // read channels
    input logic arvalid,
    output logic arready,
    input logic [7:0] araddr,
    output logic rvalid,
    input logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // register side
    output logic wr_en,
    output lfdpa_wcmd_t wr_cmd,
    input logic wr_hit,
    output logic [7:0] rd_addr,
    input logic [31:0] rd_data,
    input logic rd_hit
);
    typedef struct packed {
        logic aw_ok;
        logic w_ok;
        lfdpa_wcmd_t cmd;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } lfdpa_axs_t;

    lfdpa_axs_t s_r;
    lfdpa_axs_t s_nxt;

    assign awready = ~s_r.aw_ok & ~s_r.bvalid;
    assign wready = ~s_r.w_ok & ~s_r.bvalid;
    assign arready = ~s_r.rvalid;
    assign wr_en = s_r.aw_ok & s_r.w_ok & ~s_r.bvalid;
    assign wr_cmd = s_r.cmd;
    assign rd_addr = araddr;
    assign bvalid = s_r.bvalid;
    assign bresp = s_r.bresp;
    assign rvalid = s_r.rvalid;
    assign rdata = s_r.rdata;
    assign rresp = s_r.rresp;

    always_comb begin
        s_nxt = s_r;
        if (awvalid && awready) begin
            s_nxt.aw_ok = 1'b1;
            s_nxt.cmd.addr = awaddr;
        end
        if (wvalid && wready) begin
            s_nxt.w_ok = 1'b1;
            s_nxt.cmd.data = wdata;
            s_nxt.cmd.strb = wstrb;
        end
        if (wr_en) begin
            s_nxt.aw_ok = 1'b0;
            s_nxt.w_ok = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_r.bvalid && bready) begin
            s_nxt.bvalid = 1'b0;
        end
        if (arvalid && arready) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rdata = rd_hit ? rd_data : 32'h0000_0000;
            s_nxt.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_r.rvalid && rready) begin
            s_nxt.rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule

// [lfdpa_phy_seq.sv]
/*
 * Issues one pending transceiver register request at a time.
 * Assumes the transceiver interface runs on the same clock.
 */
`timescale 1ns/10ps
module lfdpa_phy_seq
    import lfdpa_pkg::*;
(
    // clock and reset
    input logic aclk,
    input logic aresetn,
    // pending requests from the register bank
    input logic rd_pend,
    input logic wr_pend,
    input logic [3:0] req_addr,
    input logic [7:0] req_wdata,
    output logic done_rd,
    output logic done_wr,
    // transceiver request port
    output logic phy_req_valid,
    input logic phy_req_ready,
    output lfdpa_phy_req_t phy_req
);
    typedef struct packed {
        lfdpa_seq_t state;
        lfdpa_phy_req_t req;
    } lfdpa_sq_t;

    lfdpa_sq_t s_r;
    lfdpa_sq_t s_nxt;

    assign phy_req_valid = (s_r.state == SEQ_SEND);
    assign phy_req = s_r.req;
    assign done_rd = (s_r.state == SEQ_DONE) & ~s_r.req.is_write;
    assign done_wr = (s_r.state == SEQ_DONE) & s_r.req.is_write;

    // done state gives the bank one cycle to drop the bit before idle re-looks
    always_comb begin
        s_nxt = s_r;
        unique case (s_r.state)
            SEQ_IDLE: begin
                if (rd_pend || wr_pend) begin
                    s_nxt.req = '{is_write: ~rd_pend, addr: req_addr, wdata: req_wdata};
                    s_nxt.state = SEQ_SEND;
                end
            end
            SEQ_SEND: begin
                if (phy_req_ready) begin
                    s_nxt.state = SEQ_DONE;
                end
            end
            SEQ_DONE: s_nxt.state = SEQ_IDLE;
            default: s_nxt.state = SEQ_IDLE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule

// [lfdpa_phy_model.sv]
/*
 * Behavioural transceiver on the far side of the register port.
 * Assumes one request at a time, answered after a programmable stall.
 */
`timescale 1ns/10ps
module lfdpa_phy_model
    import lfdpa_pkg::*;
(
    // clock, reset and stall length
    input logic aclk,
    input logic aresetn,
    input logic [1:0] stall,
    // request and reply
    input logic phy_req_valid,
    output logic phy_req_ready,
    input lfdpa_phy_req_t phy_req,
    output logic phy_reply_valid,
    output lfdpa_phy_reply_t phy_reply
);
    logic [7:0] mem [16];
    logic [1:0] cnt;
    always @(posedge aclk) begin
        phy_req_ready <= 1'b0;
        phy_reply_valid <= 1'b0;
        // idle reply lines toggle so stale data never looks valid
        phy_reply <= ~phy_reply;
        cnt <= 2'h0;
        if (!aresetn) begin
            phy_reply <= 12'h5A5;
            for (int i = 0; i < 16; i++) mem[i] <= 8'h00;
        end else if (phy_req_valid && !phy_req_ready) begin
            if (cnt == stall) begin
                phy_req_ready <= 1'b1;
                if (phy_req.is_write) mem[phy_req.addr] <= phy_req.wdata;
                else begin
                    phy_reply_valid <= 1'b1;
                    phy_reply <= {phy_req.addr, mem[phy_req.addr]};
                end
            end else cnt <= cnt + 2'h1;
        end
    end
endmodule

// [lfdpa_link_regs_tb.sv]
/*
 * Self-checking bench for the link register group.
 * Assumes the transceiver model answers every request it sees.
 */
`timescale 1ns/10ps
module lfdpa_link_regs_tb
    import lfdpa_pkg::*;
;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0] awaddr = 0, araddr = 0, pd;
    logic [31:0] wdata = 0, rdata, d;
    logic [3:0] wstrb = 0, pa;
    logic awready, wready, bvalid, arready, rvalid, fa, fi, fg, tact, cap, unl, irq;
    logic phy_req_valid, phy_req_ready, phy_reply_valid, pre = 0, bad = 0;
    logic [1:0] bresp, rresp, resp, dly = 0;
    logic [8:0] atxd, itxd, tqo, at, it, tq;
    logic [9:0] grxd;
    logic [32:0] qmask;
    lfdpa_phy_req_t phy_req, h0, h1;
    lfdpa_phy_reply_t phy_reply;
    logic [7:0] shadow [16];
    int num_errors = 0, compares = 0, seed = 32'hc34a, nfa = 0, nfi = 0, nfg = 0, nirq = 0, n, n0;

    lfdpa_link_regs u_dut (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
        .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp,
        .flush_async_tx_queue(fa), .flush_iso_tx_queue(fi), .flush_general_rx_queue(fg),
        .async_tx_queue_depth(atxd), .iso_tx_queue_depth(itxd), .general_rx_queue_depth(grxd),
        .queue_word_mask(qmask), .partial_read_enable(pre), .bad_header_flag(bad), .trigger_size_active(tact),
        .trigger_size_quadlets(tqo), .capture_all_enable(cap), .full_write_unlock(unl), .phy_req_valid,
        .phy_req_ready, .phy_req, .phy_reply_valid, .phy_reply, .transceiver_info_irq(irq));
    lfdpa_phy_model u_phy (.aclk, .aresetn, .stall(dly), .phy_req_valid, .phy_req_ready, .phy_req,
        .phy_reply_valid, .phy_reply);

    always #10 aclk = ~aclk;
    always @(posedge aclk) begin
        nfa <= nfa + int'(fa === 1'b1);
        nfi <= nfi + int'(fi === 1'b1);
        nfg <= nfg + int'(fg === 1'b1);
        nirq <= nirq + int'(irq === 1'b1);
        if (phy_req_valid === 1'b1 && phy_req_ready === 1'b1) begin
            h0 <= h1;
            h1 <= phy_req;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge aclk);
        awvalid <= 1;
        awaddr <= a;
        wvalid <= 1;
        wdata <= v;
        wstrb <= 4'hF;
        bready <= 1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end while (bvalid !== 1'b1 && n < 50);
        resp = bresp;
        bready <= 0;
        chk(32'(n < 50), 1);
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        arvalid <= 1;
        araddr <= a;
        rready <= 1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (arready) arvalid <= 0;
        end while (rvalid !== 1'b1 && n < 50);
        d = rdata;
        resp = rresp;
        rready <= 0;
        chk(32'(n < 50), 1);
    endtask
    task automatic print_verdict();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        #1000000;
        num_errors++;
        print_verdict();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        for (int i = 0; i < 16; i++) shadow[i] = 8'h00;
        repeat (6) @(posedge aclk);
        aresetn <= 1;
        rd(OFS_TEST_OBSERVE_CTRL);
        chk(d, RST_TEST_OBSERVE_CTRL);
        rd(OFS_TRANSCEIVER_REG_PORT);
        chk(d, RST_TRANSCEIVER_REG_PORT);
        rd(8'h28);
        chk(resp, RESP_SLVERR);
        wr(8'h28, 32'hFFFF_FFFF);
        chk(resp, RESP_SLVERR);
        chk(qmask[32:1], 32'h8000_0000);
        for (int b = 0; b < 3; b++) begin
            wr(OFS_QUEUE_PARTITION_CTRL, (32'h8000_0000 >> b) | 32'h1800_0000);
            @(negedge aclk);
            chk({8'(nfa), 8'(nfi), 8'(nfg)}, {8'h1, 8'(b >= 1), 8'(b >= 2)});
            rd(OFS_QUEUE_PARTITION_CTRL);
            chk(d, 32'h0);
        end
        for (int i = 0; i < 10; i++) begin
            at = (i == 0) ? 9'h100 : 9'($random(seed));
            it = (i == 0) ? 9'h100 : 9'($random(seed));
            // software side keeps the two transmit depths within the shared memory
            if (10'(at) + 10'(it) > 10'h200) it = 9'(10'h200 - 10'(at));
            tq = 9'($random(seed));
            wr(OFS_QUEUE_PARTITION_CTRL, {5'h0, tq, at, it});
            @(negedge aclk);
            chk({grxd, atxd, itxd}, {10'h200 - 10'(at) - 10'(it), at, it});
            chk({tact, tqo}, (pre && !bad) ? {1'b1, tq} : 10'h0);
            rd(OFS_QUEUE_PARTITION_CTRL);
            chk(d, {5'h0, tq, at, it});
            pre <= 1'($random(seed));
            bad <= 1'($random(seed));
        end
        wr(OFS_TEST_OBSERVE_CTRL, 32'hFFFF_FFFF);
        chk(resp, RESP_OKAY);
        @(negedge aclk);
        chk({cap, unl}, 2'b11);
        rd(OFS_TEST_OBSERVE_CTRL);
        chk(d, 32'h8800_0000);
        wr(OFS_TRANSCEIVER_REG_PORT, 32'h0000_0ABC);
        rd(OFS_TRANSCEIVER_REG_PORT);
        chk(d, 32'h0000_0ABC);
        wr(OFS_TEST_OBSERVE_CTRL, 32'h8000_0000);
        wr(OFS_TRANSCEIVER_REG_PORT, 32'h3FFF_F123);
        rd(OFS_TRANSCEIVER_REG_PORT);
        chk(d, 32'h0FFF_0ABC);
        for (int i = 0; i < 6; i++) begin
            pa = 4'($random(seed));
            pd = 8'($random(seed));
            dly <= 2'(i);
            n0 = nirq;
            // both bits at once: the read goes out first, then the write
            // transceiver writes are how software keeps gap counts equal
            wr(OFS_TRANSCEIVER_REG_PORT, {4'hC, pa, pd, 16'h0});
            for (int k = 0; k < 30; k++) begin
                rd(OFS_TRANSCEIVER_REG_PORT);
                if (d[31:30] === 2'b00) break;
            end
            @(negedge aclk);
            chk(d[31:30], 2'b00);
            chk({h0[12:8], h1}, {1'b0, pa, 1'b1, pa, pd});
            chk(d[11:0], {pa, shadow[pa]});
            chk(nirq - n0, 1);
            shadow[pa] = pd;
        end
        print_verdict();
    end
endmodule
